// ### common/spx_pkg.sv
// Shared types and constants for the four-mode serial port.
// Assumes one system clock; the machine cycle, shift clock and divider figures count its cycles.
package spx_pkg;

    // Port mode as coded by the two mode select bits.
    typedef enum logic [1:0] {
        SPX_MODE0 = 2'b00,
        SPX_MODE1 = 2'b01,
        SPX_MODE2 = 2'b10,
        SPX_MODE3 = 2'b11
    } spx_mode_t;

    // Transmitter states.
    typedef enum logic [1:0] {
        SPX_TX_IDLE  = 2'b00,
        SPX_TX_ASYNC = 2'b01,
        SPX_TX_SYNC  = 2'b10,
        SPX_TX_WAIT  = 2'b11
    } spx_tx_st_t;

    // Receiver states.
    typedef enum logic [1:0] {
        SPX_RX_IDLE  = 2'b00,
        SPX_RX_ASYNC = 2'b01,
        SPX_RX_SYNC  = 2'b10,
        SPX_RX_WAIT  = 2'b11
    } spx_rx_st_t;

    // Control bits written by software.
    typedef struct packed {
        logic mode_sel_high;
        logic mode_sel_low;
        logic multiproc_or_rate_sel;
        logic rx_enable;
        logic tx_ninth_bit;
        logic baud_double_sel;
    } spx_cfg_t;

    // Status bits read by software.
    typedef struct packed {
        logic tx_done_flag;
        logic rx_done_flag;
        logic rx_ninth_bit;
    } spx_stat_t;

    // Machine cycle: twelve clocks, state 6 phase 2 is the last one.
    localparam logic [3:0] SPX_MC_LAST = 4'hB;
    localparam logic [3:0] SPX_STATE6_PHASE2_IDX = 4'hB;

    // Synchronous shift clock, slow rate (one twelfth of the clock).
    localparam logic [3:0] SPX_M0_SLOW_LAST = 4'hB;
    localparam logic [3:0] SPX_M0_SLOW_FALL = 4'h3;
    localparam logic [3:0] SPX_M0_SLOW_RISE = 4'h9;
    // Synchronous shift clock, fast rate (one quarter of the clock).
    localparam logic [3:0] SPX_M0_FAST_LAST = 4'h3;
    localparam logic [3:0] SPX_M0_FAST_FALL = 4'h1;
    localparam logic [3:0] SPX_M0_FAST_RISE = 4'h3;
    localparam logic [3:0] SPX_M0_BITS_LAST = 4'h7;

    // Oversampling counter and majority sample points.
    localparam logic [3:0] SPX_OVS_LAST = 4'hF;
    localparam logic [3:0] SPX_SMP_A = 4'h8;
    localparam logic [3:0] SPX_SMP_B = 4'h9;
    localparam logic [3:0] SPX_SMP_C = 4'hA;

    // Index of the last bit of a 10-bit and an 11-bit frame.
    localparam logic [3:0] SPX_M1_LAST = 4'h9;
    localparam logic [3:0] SPX_M2_LAST = 4'hA;

    // Mode 2 oversampling tick divider: every 2 or every 4 clocks.
    localparam logic [1:0] SPX_M2_DIV_FAST = 2'h1;
    localparam logic [1:0] SPX_M2_DIV_SLOW = 2'h3;

    // Reset values.
    localparam logic SPX_LINE_IDLE = 1'b1;
    localparam logic [7:0] SPX_BUF_RST = 8'h00;

endpackage

// ### design/spx_serial_port.sv
// Four-mode serial port: synchronous shift mode and 10/11-bit async modes,
// with an 8-word write FIFO in front of the transmitter.
// Assumes the timer overflow pulse is on clk; the receive pin is asynchronous.
`timescale 1ns/100ps

module spx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
    logic [AW-1:0] wr_ptr_ff;       // Next slot to write.
    logic [AW-1:0] rd_ptr_ff;       // Next slot to read.
    logic [CW-1:0] count_ff;        // Words held.
    logic ready_ff;                 // Room for one more word.
    logic push;
    logic pop;
    logic [CW-1:0] nxt_count;

    assign push = in_valid & ready_ff;
    assign pop = out_valid & out_ready;
    assign in_ready = ready_ff;
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];

    // Count follows pushes and pops.
    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + CW'(1);
        end else if (pop && !push) begin
            nxt_count = count_ff - CW'(1);
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ready_ff <= 1'b1;
        end else begin
            count_ff <= nxt_count;
            ready_ff <= (nxt_count != CW'(DEPTH));
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
            end
        end
    end

    // Storage has no reset; only written slots are ever read.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end
endmodule

module spx_serial_port #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Buffer access from the processor.
    input wire logic buf_wr,
    input wire logic [7:0] buf_wdata,
    output logic buf_wr_ready,
    output logic [7:0] serial_buffer,
    // Control and status.
    input wire spx_pkg::spx_cfg_t cfg,
    input wire logic tx_done_clr,
    input wire logic rx_done_clr,
    output spx_pkg::spx_stat_t stat,
    // Baud source.
    input wire logic t1_overflow,
    // Serial pins.
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out
);
    spx_pkg::spx_mode_t mode;        // Decoded port mode.
    spx_pkg::spx_tx_st_t tx_st_ff;   // Transmitter state.
    spx_pkg::spx_rx_st_t rx_st_ff;   // Receiver state.
    spx_pkg::spx_stat_t stat_ff;     // Software-visible flags.
    logic [3:0] mc_ff;               // Machine cycle clock index.
    logic [3:0] sc_ff;               // Shift clock period index.
    logic [1:0] div_ff;              // Mode 2 clock divider.
    logic t1_half_ff;                // Halves the timer overflow rate.
    logic [3:0] txc_ff;              // Transmit divide-by-16 counter.
    logic [3:0] rxc_ff;              // Receive divide-by-16 counter.
    logic [3:0] tx_bits_ff;          // Transmit bit index.
    logic [3:0] rx_bits_ff;          // Receive bit index.
    logic [10:0] tx_sh_ff;           // Transmit shifter, LSB goes out first.
    logic [8:0] rx_sh_ff;            // Receive shifter, fills from the top.
    logic [1:0] smp_ff;              // First two majority samples.
    logic rxd_meta_ff;               // Pin synchroniser, first stage.
    logic rxd_sync_ff;               // Pin synchroniser, second stage.
    logic rxd_prev_ff;               // Previous synchronised level.
    logic [7:0] buf_ff;              // Receive buffer.
    logic txd_ff;                    // Transmit pin level.
    logic rxd_out_ff;                // Data pin drive level.
    logic rxd_oe_ff;                 // Data pin drive enable.
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;
    logic state6_phase2;             // Last clock of the machine cycle.
    logic ovs_tick;                  // Sixteen times the bit rate.
    logic tx_roll;                   // Transmit counter rollover.
    logic m0_run;                    // Shift clock running.
    logic [3:0] m0_last;
    logic [3:0] m0_fall;
    logic [3:0] m0_rise;
    logic [3:0] frame_last;
    logic rx_bit;                    // Majority decision.
    logic rx_ninth_val;
    logic [7:0] rx_data_val;
    logic rx_load;
    logic tx_set;
    logic rx_set;

    // Two-of-three vote over the bit samples.
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    assign mode = spx_pkg::spx_mode_t'({cfg.mode_sel_high, cfg.mode_sel_low});

    spx_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(buf_wr),
        .in_ready(buf_wr_ready),
        .in_data(buf_wdata),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // Outputs all come from registers.
    assign serial_buffer = buf_ff;
    assign stat = stat_ff;
    assign txd_out = txd_ff;
    assign rxd_out = rxd_out_ff;
    assign rxd_oe = rxd_oe_ff;

    // Timing selections and strobes derived from the mode.
    always_comb begin
        state6_phase2 = (mc_ff == spx_pkg::SPX_STATE6_PHASE2_IDX);
        m0_run = (tx_st_ff == spx_pkg::SPX_TX_SYNC) || (rx_st_ff == spx_pkg::SPX_RX_SYNC);
        if (cfg.multiproc_or_rate_sel) begin
            m0_last = spx_pkg::SPX_M0_FAST_LAST;
            m0_fall = spx_pkg::SPX_M0_FAST_FALL;
            m0_rise = spx_pkg::SPX_M0_FAST_RISE;
        end else begin
            m0_last = spx_pkg::SPX_M0_SLOW_LAST;
            m0_fall = spx_pkg::SPX_M0_SLOW_FALL;
            m0_rise = spx_pkg::SPX_M0_SLOW_RISE;
        end
        frame_last = (mode == spx_pkg::SPX_MODE1) ? spx_pkg::SPX_M1_LAST : spx_pkg::SPX_M2_LAST;
        if (mode == spx_pkg::SPX_MODE2) begin
            ovs_tick = cfg.baud_double_sel ? (div_ff[0] == spx_pkg::SPX_M2_DIV_FAST[0])
                                           : (div_ff == spx_pkg::SPX_M2_DIV_SLOW);
        end else begin
            ovs_tick = t1_overflow & (cfg.baud_double_sel | t1_half_ff);
        end
        tx_roll = ovs_tick && (txc_ff == spx_pkg::SPX_OVS_LAST);
    end

    // Receive decision and acceptance for the async frame.
    always_comb begin
        rx_bit = maj3(smp_ff[0], smp_ff[1], rxd_sync_ff);
        if (mode == spx_pkg::SPX_MODE1) begin
            rx_data_val = rx_sh_ff[8:1];
            rx_ninth_val = rx_bit;
        end else begin
            rx_data_val = rx_sh_ff[7:0];
            rx_ninth_val = rx_sh_ff[8];
        end
        rx_load = (rx_st_ff == spx_pkg::SPX_RX_ASYNC) && ovs_tick
                  && (rxc_ff == spx_pkg::SPX_SMP_C) && (rx_bits_ff == frame_last)
                  && !stat_ff.rx_done_flag && (!cfg.multiproc_or_rate_sel || rx_ninth_val);
        tx_set = ((tx_st_ff == spx_pkg::SPX_TX_ASYNC) && tx_roll && (tx_bits_ff == frame_last))
                 || ((tx_st_ff == spx_pkg::SPX_TX_WAIT) && state6_phase2);
        rx_set = rx_load || ((rx_st_ff == spx_pkg::SPX_RX_WAIT) && state6_phase2);
        fifo_ready = (tx_st_ff == spx_pkg::SPX_TX_IDLE)
                     && ((mode != spx_pkg::SPX_MODE0) || (rx_st_ff == spx_pkg::SPX_RX_IDLE));
    end

    // Receive pin passes two flip-flops before any logic reads it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxd_meta_ff <= spx_pkg::SPX_LINE_IDLE;
            rxd_sync_ff <= spx_pkg::SPX_LINE_IDLE;
            rxd_prev_ff <= spx_pkg::SPX_LINE_IDLE;
        end else begin
            rxd_meta_ff <= rxd_in;
            rxd_sync_ff <= rxd_meta_ff;
            rxd_prev_ff <= rxd_sync_ff;
        end
    end

    // Machine cycle counter and the baud dividers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mc_ff <= '0;
            div_ff <= '0;
            t1_half_ff <= 1'b0;
            txc_ff <= '0;
        end else begin
            mc_ff <= (mc_ff == spx_pkg::SPX_MC_LAST) ? '0 : mc_ff + 4'h1;
            div_ff <= div_ff + 2'h1;
            if (t1_overflow) begin
                t1_half_ff <= ~t1_half_ff;
            end
            if (ovs_tick) begin
                txc_ff <= txc_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sc_ff <= '0;
        end else if (!m0_run || (sc_ff == m0_last)) begin
            sc_ff <= '0;
        end else begin
            sc_ff <= sc_ff + 4'h1;
        end
    end

    // Transmitter sequencing.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_st_ff <= spx_pkg::SPX_TX_IDLE;
            tx_sh_ff <= '1;
            tx_bits_ff <= '0;
        end else begin
            case (tx_st_ff)
                spx_pkg::SPX_TX_IDLE: begin
                    tx_bits_ff <= '0;
                    if (fifo_valid && fifo_ready) begin
                        if (mode == spx_pkg::SPX_MODE0) begin
                            tx_sh_ff <= {3'h7, fifo_data};
                            tx_st_ff <= spx_pkg::SPX_TX_SYNC;
                        end else begin
                            tx_sh_ff <= {1'b1,
                                         (mode == spx_pkg::SPX_MODE1) | cfg.tx_ninth_bit,
                                         fifo_data, 1'b0};
                            tx_st_ff <= spx_pkg::SPX_TX_ASYNC;
                        end
                    end
                end
                spx_pkg::SPX_TX_ASYNC: begin
                    if (tx_roll) begin
                        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                        tx_bits_ff <= tx_bits_ff + 4'h1;
                        if (tx_bits_ff == frame_last) begin
                            tx_st_ff <= spx_pkg::SPX_TX_IDLE;
                        end
                    end
                end
                spx_pkg::SPX_TX_SYNC: begin
                    if (sc_ff == m0_last) begin
                        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                        tx_bits_ff <= tx_bits_ff + 4'h1;
                        if (tx_bits_ff == spx_pkg::SPX_M0_BITS_LAST) begin
                            tx_st_ff <= spx_pkg::SPX_TX_WAIT;
                        end
                    end
                end
                default: begin
                    if (state6_phase2) begin
                        tx_st_ff <= spx_pkg::SPX_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receiver sequencing.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_st_ff <= spx_pkg::SPX_RX_IDLE;
            rx_sh_ff <= '0;
            rx_bits_ff <= '0;
            rxc_ff <= '0;
            smp_ff <= '0;
        end else begin
            case (rx_st_ff)
                spx_pkg::SPX_RX_IDLE: begin
                    rx_bits_ff <= '0;
                    rxc_ff <= '0;
                    if (mode == spx_pkg::SPX_MODE0) begin
                        if (cfg.rx_enable && !stat_ff.rx_done_flag
                            && (tx_st_ff == spx_pkg::SPX_TX_IDLE) && !fifo_valid) begin
                            rx_st_ff <= spx_pkg::SPX_RX_SYNC;
                        end
                    end else if (cfg.rx_enable && rxd_prev_ff && !rxd_sync_ff) begin
                        rx_st_ff <= spx_pkg::SPX_RX_ASYNC;
                    end
                end
                spx_pkg::SPX_RX_ASYNC: begin
                    if (ovs_tick) begin
                        rxc_ff <= rxc_ff + 4'h1;
                        if (rxc_ff == spx_pkg::SPX_SMP_A) begin
                            smp_ff[0] <= rxd_sync_ff;
                        end else if (rxc_ff == spx_pkg::SPX_SMP_B) begin
                            smp_ff[1] <= rxd_sync_ff;
                        end else if (rxc_ff == spx_pkg::SPX_SMP_C) begin
                            rx_bits_ff <= rx_bits_ff + 4'h1;
                            if ((rx_bits_ff == '0) && rx_bit) begin
                                rx_st_ff <= spx_pkg::SPX_RX_IDLE;
                            end else if (rx_bits_ff == frame_last) begin
                                rx_st_ff <= spx_pkg::SPX_RX_IDLE;
                            end else if (rx_bits_ff != '0) begin
                                rx_sh_ff <= {rx_bit, rx_sh_ff[8:1]};
                            end
                        end
                    end
                end
                spx_pkg::SPX_RX_SYNC: begin
                    if (sc_ff == m0_rise) begin
                        rx_sh_ff <= {rxd_sync_ff, rx_sh_ff[8:1]};
                    end
                    if (sc_ff == m0_last) begin
                        rx_bits_ff <= rx_bits_ff + 4'h1;
                        if (rx_bits_ff == spx_pkg::SPX_M0_BITS_LAST) begin
                            rx_st_ff <= spx_pkg::SPX_RX_WAIT;
                        end
                    end
                end
                default: begin
                    if (state6_phase2) begin
                        rx_st_ff <= spx_pkg::SPX_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive buffer and flags; a set beats a clear in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            buf_ff <= spx_pkg::SPX_BUF_RST;
            stat_ff <= '0;
        end else begin
            if (rx_load) begin
                buf_ff <= rx_data_val;
                stat_ff.rx_ninth_bit <= rx_ninth_val;
            end else if (rx_st_ff == spx_pkg::SPX_RX_WAIT && state6_phase2) begin
                buf_ff <= rx_sh_ff[8:1];
            end
            stat_ff.tx_done_flag <= tx_set | (stat_ff.tx_done_flag & ~tx_done_clr);
            stat_ff.rx_done_flag <= rx_set | (stat_ff.rx_done_flag & ~rx_done_clr);
        end
    end

    // Pin drivers: shift clock and data in mode 0, serial line otherwise.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txd_ff <= spx_pkg::SPX_LINE_IDLE;
            rxd_out_ff <= spx_pkg::SPX_LINE_IDLE;
            rxd_oe_ff <= 1'b0;
        end else begin
            // data line driven only while sending
            rxd_oe_ff <= (tx_st_ff == spx_pkg::SPX_TX_SYNC);
            if (m0_run) begin
                if (sc_ff == '0) begin
                    rxd_out_ff <= tx_sh_ff[0];
                end
                if (sc_ff == m0_fall) begin
                    txd_ff <= 1'b0;
                end else if (sc_ff == m0_rise) begin
                    txd_ff <= 1'b1;
                end
            end else if (tx_st_ff == spx_pkg::SPX_TX_ASYNC) begin
                if (tx_roll) begin
                    txd_ff <= tx_sh_ff[0];
                end
            end else begin
                txd_ff <= spx_pkg::SPX_LINE_IDLE;
            end
        end
    end
endmodule

// ### sim/spx_serial_port_assertions.sv
// Timing and flag checks on the serial port pins, bound to the port.
// Assumes cfg is held still while a frame is on the wire.
`timescale 1ns/100ps
module spx_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Processor side.
    input wire logic [7:0] serial_buffer,
    input wire spx_pkg::spx_cfg_t cfg,
    input wire logic tx_done_clr,
    input wire logic rx_done_clr,
    input wire spx_pkg::spx_stat_t stat,
    // Serial pins.
    input wire logic rxd_oe,
    input wire logic txd_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic m0;  // High in the synchronous shift mode.
    assign m0 = !cfg.mode_sel_high && !cfg.mode_sel_low;
    chk_reset_idle: assert property (
        $rose(resetn) |-> txd_out && !rxd_oe && stat == 3'h0) else $error("reset idle");
    chk_drive_sync: assert property (
        rxd_oe |-> m0) else $error("data pin driven outside sync mode");
    chk_fast_low: assert property (
        m0 && cfg.multiproc_or_rate_sel && $fell(txd_out) |-> ##1 !txd_out ##1 txd_out)
        else $error("fast shift clock low time");
    chk_slow_low: assert property (
        m0 && !cfg.multiproc_or_rate_sel && $fell(txd_out) |-> (!txd_out)[*6] ##1 txd_out)
        else $error("slow shift clock low time");
    chk_async_bit: assert property (
        !m0 && cfg.baud_double_sel && $changed(txd_out) |=> $stable(txd_out)[*8])
        else $error("async bit too short");
    chk_rx_clear: assert property (
        $fell(stat.rx_done_flag) |-> $past(rx_done_clr)) else $error("rx flag lost");
    chk_tx_clear: assert property (
        $fell(stat.tx_done_flag) |-> $past(tx_done_clr)) else $error("tx flag lost");
    chk_buf_load: assert property (
        $changed(serial_buffer) |-> $rose(stat.rx_done_flag)) else $error("buffer load");
    chk_ninth_load: assert property (
        $changed(stat.rx_ninth_bit) |-> $rose(stat.rx_done_flag)) else $error("ninth load");
    cover property (m0 && $rose(stat.rx_done_flag));
    cover property (!m0 && $rose(stat.rx_done_flag));
    cover property (!m0 && $rose(stat.tx_done_flag));
endmodule
bind spx_serial_port spx_chk u_chk (.clk(clk), .resetn(resetn), .serial_buffer(serial_buffer),
    .cfg(cfg), .tx_done_clr(tx_done_clr), .rx_done_clr(rx_done_clr), .stat(stat),
    .rxd_oe(rxd_oe), .txd_out(txd_out));

// ### sim/spx_line_model.sv
// Far end of the link: an async sender and a sync shift register.
// Assumes the bench reads its line only while the port is not driving.
`timescale 1ns/100ps
module spx_line_model (
    // Clock and the port's shift clock.
    input wire logic clk,
    input wire logic sclk,
    // Level put on the data line.
    output logic line
);
    logic sclk_q;  // Shift clock one clock ago.
    logic [7:0] m0_data;  // Byte to shift in.
    int m0_idx;  // Next bit; 8 waits for the last rise, 9 is idle.
    initial begin
        line = 1'b1;
        sclk_q = 1'b1;
        m0_idx = 9;
    end
    always @(posedge clk) begin
        sclk_q <= sclk;
        if (sclk_q && !sclk && m0_idx < 8) begin
            line <= m0_data[m0_idx];
            m0_idx <= m0_idx + 1;
        end else if (!sclk_q && sclk && m0_idx == 8) begin
            line <= ~line;  // Released: show the inverse, not the last bit.
            m0_idx <= 9;
        end
    end
    task automatic arm(input logic [7:0] d);
        m0_data = d;
        m0_idx = 0;
    endtask
    // Sends nb bits of bl clocks each, start bit first.
    task automatic send(input logic [7:0] d, input logic n9, input int nb, input int bl);
        logic [10:0] f;
        f = {1'h1, (nb == 10) | n9, d, 1'h0};
        // A released sync data line may rest low; idle high for one bit before the start.
        line = 1'b1;
        repeat (bl) @(negedge clk);
        for (int i = 0; i < nb; i++) begin
            @(negedge clk);
            line = f[i];
            repeat (bl - 1) @(negedge clk);
        end
    endtask
endmodule

// ### sim/tb_spx_serial_port.sv
// Bench for the serial port: every mode and rate through the pins.
// Assumes the line model drives the data pin whenever the port does not.
`timescale 1ns/100ps
module tb_spx_serial_port;
    logic clk, resetn, buf_wr, buf_wr_ready, tx_done_clr, rx_done_clr;
    logic t1_overflow = 1'b0;  // Driven only by its toggling process.
    logic rxd_in, rxd_out, rxd_oe, txd_out, line;
    logic [7:0] buf_wdata, serial_buffer;
    logic [10:0] v;  // Last decoded frame.
    spx_pkg::spx_cfg_t cfg;
    spx_pkg::spx_stat_t stat;
    int errors = 0, check_count = 0, cycles = 0;
    assign rxd_in = rxd_oe ? rxd_out : line;  // Pin level from both drivers.
    spx_serial_port dut (.clk(clk), .resetn(resetn), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
        .buf_wr_ready(buf_wr_ready), .serial_buffer(serial_buffer), .cfg(cfg),
        .tx_done_clr(tx_done_clr), .rx_done_clr(rx_done_clr), .stat(stat),
        .t1_overflow(t1_overflow), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .txd_out(txd_out));
    spx_line_model pm (.clk(clk), .sclk(txd_out), .line(line));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Timer overflow on every second clock; the guard ends a hung run.
    always @(negedge clk) t1_overflow <= ~t1_overflow;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic put(input logic [5:0] c, input logic w, input logic [7:0] d);
        @(negedge clk);
        cfg = c;
        buf_wr = w;
        buf_wdata = d;
        @(negedge clk);
        buf_wr = 1'b0;
    endtask
    task automatic clr(input logic t);
        @(negedge clk);
        tx_done_clr = t;
        rx_done_clr = !t;
        @(negedge clk);
        tx_done_clr = 1'b0;
        rx_done_clr = 1'b0;
    endtask
    // Async frames are sampled mid-bit; sync bits at each shift clock rise.
    task automatic get(input int nb, input int bl);
        v = 11'h000;
        if (bl == 0) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge txd_out);
                v[i] = rxd_out;
            end
        end else begin
            while (txd_out !== 1'b0) @(negedge clk);
            for (int i = 0; i < nb; i++) begin
                repeat ((i == 0) ? bl / 2 : bl) @(negedge clk);
                v[i] = txd_out;
            end
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] d;
        int nb, bl;
        {resetn, buf_wr, tx_done_clr, rx_done_clr} = 4'h0;
        buf_wdata = 8'h00;
        cfg = 6'h00;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        for (int r = 0; r < 2; r++) begin
            put({2'h0, r[0], 3'h0}, 1'b1, 8'hA6 ^ r[7:0]);
            get(8, 0);
            chk("sync tx", {3'h0, 8'hA6 ^ r[7:0]}, v);
            while (stat.tx_done_flag !== 1'b1) @(negedge clk);
            clr(1'b1);
        end
        pm.arm(8'hC5);
        put(6'h04, 1'b0, 8'h00);
        while (stat.rx_done_flag !== 1'b1) @(negedge clk);
        put(6'h00, 1'b0, 8'h00);
        chk("sync rx", {3'h0, 8'hC5}, {3'h0, serial_buffer});
        clr(1'b0);
        for (int m = 1; m < 4; m++) begin
            for (int b = 0; b < 2; b++) begin
                nb = (m == 1) ? 10 : 11;
                bl = b ? 32 : 64;
                d = {m[3:0], 4'h5} ^ {7'h00, b[0]};
                put({m[1:0], 2'h1, b[0], b[0]}, 1'b1, d);
                get(nb, bl);
                chk("frame", {nb == 11, (nb == 10) | b[0], d, 1'h0}, v);
                chk("tx done", 11'h001, {10'h000, stat.tx_done_flag});
                clr(1'b1);
                pm.send(~d, b[0], nb, bl);
                repeat (4) @(negedge clk);
                chk("rx", {2'h1, (nb == 10) | b[0], ~d}, {1'h0, stat[1:0], serial_buffer});
                clr(1'b0);
            end
        end
        put(6'h2D, 1'b0, 8'h00);
        pm.send(8'h96, 1'b0, 11, 32);
        pm.send(8'h69, 1'b1, 11, 32);
        repeat (4) @(negedge clk);
        chk("filter", {3'h3, 8'h69}, {1'h0, stat[1:0], serial_buffer});
        pm.send(8'h17, 1'b1, 11, 32);
        chk("held", {3'h3, 8'h69}, {1'h0, stat[1:0], serial_buffer});
        clr(1'b0);
        @(negedge clk);
        cfg = 6'h21;
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            buf_wr = 1'b1;
            buf_wdata = 8'h40 + i[7:0];
        end
        @(negedge clk);
        buf_wr = 1'b0;
        chk("full", 11'h000, {10'h000, buf_wr_ready});
        for (int i = 0; i < 9; i++) begin
            get(11, 32);
            chk("order", {2'h2, 8'h40 + i[7:0], 1'h0}, v);
        end
        report_and_stop();
    end
endmodule
